//--- common/msr_map.vh
/*
 memory sync / reservation unit constants: opcodes, fields, widths.
 assumes big-endian bit numbering of 32-bit instructions as used by the pipeline.
*/
`ifndef MSR_MAP_VH
`define MSR_MAP_VH
// ==========================================
// primary and extended opcodes
`define MSR_OP_PRIMARY_31 6'h1F
`define MSR_OP_PRIMARY_19 6'h13
`define MSR_XO_SYNC 10'h256
`define MSR_XO_IO_ORDER 10'h356
`define MSR_XO_ISYNC 10'h096
`define MSR_XO_LOAD_RSV 10'h014
`define MSR_XO_STORE_COND 10'h096
`define MSR_XO_COND_READ 10'h013
`define MSR_XO_COND_WRITE 10'h090
`define MSR_XO_FPX_TO_COND 10'h200
`define MSR_XO_SPR_READ 10'h153
// ==========================================
// field positions and widths
`define MSR_GRANULE_LSB 5
`define MSR_XO_BIT25_POS 5
`define MSR_COND_RESET 32'h00000000
`define MSR_RSV_RESET 1'b0
`define MSR_CR0_EQ_POS 29
`endif

//--- hw/msr_gran_cmp.v
/*
 reservation granule comparator.
 assumes addresses are byte addresses from the load/store unit.
*/
`timescale 1ns/1ps
module msr_gran_cmp (
    input wire [31:0] addr_a_i,
    input wire [31:0] addr_b_i,
    output wire hit_o
);
`include "msr_map.vh"
    // low five bits ignored: one aligned 32-byte section
    assign hit_o = (addr_a_i[31:`MSR_GRANULE_LSB] == addr_b_i[31:`MSR_GRANULE_LSB]);
endmodule // msr_gran_cmp

//--- hw/msr_sync_unit.v
/*
 memory synchronisation and reservation unit of the core: barriers, isync flush,
 reservation tracker, condition register moves, time base read decode.
 assumes the pipeline presents one decoded instruction with issue_valid_i and holds it
 while stall_o is high; snoop inputs come from the bus interface on the same clock.
 all pending levels come from logic on the core clock, so none of them is synchronised.
 the unit has no bus port of its own; bus_req_o stays low so the barriers stay local.
*/
`timescale 1ns/1ps
module msr_sync_unit (
    input wire clk_i,
    input wire rst_b_i,
    input wire issue_valid_i,
    input wire [31:0] instr_i,
    input wire [31:0] instr_addr_i,
    input wire [31:0] effective_address_i,
    input wire [31:0] gpr_src_i,
    input wire [31:0] fixed_point_exception_reg_i,
    input wire write_through_i,
    input wire prior_excp_pending_i,
    input wire prior_mem_pending_i,
    input wire prior_touch_xlate_pending_i,
    input wire snoop_write_valid_i,
    input wire [31:0] snoop_addr_i,
    output wire stall_o,
    output reg flush_o,
    output reg [31:0] refetch_addr_o,
    output reg store_perform_o,
    output reg gpr_wr_en_o,
    output reg [31:0] gpr_wr_data_o,
    output reg fpx_clear_o,
    output reg spr_read_o,
    output reg dsi_excp_o,
    output wire bus_req_o,
    output reg [31:0] condition_register_o,
    output reg rsv_valid_o
);
`include "msr_map.vh"
    // ==========================================
    // reset release
    reg rst_s1_reg;
    reg rst_s2_reg;
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire rst_b = rst_s2_reg;

    // ==========================================
    // decode
    function is_x31;
        input [31:0] ins;
        input [9:0] xo;
        begin
            is_x31 = (ins[31:26] == `MSR_OP_PRIMARY_31) && (ins[10:1] == xo);
        end
    endfunction
    // word bit 25 (big-endian) is instr_i[6], which is bit 5 of the extended opcode
    wire [9:0] xo_nb25 = instr_i[10:1] & 10'h3DF;
    wire dec_sync = issue_valid_i && is_x31(instr_i, `MSR_XO_SYNC);
    wire dec_ioord = issue_valid_i && is_x31(instr_i, `MSR_XO_IO_ORDER);
    wire dec_isync = issue_valid_i && (instr_i[31:26] == `MSR_OP_PRIMARY_19) &&
        (instr_i[10:1] == `MSR_XO_ISYNC);
    wire dec_lrsv = issue_valid_i && is_x31(instr_i, `MSR_XO_LOAD_RSV);
    wire dec_scond = issue_valid_i && is_x31(instr_i, `MSR_XO_STORE_COND);
    wire dec_crrd = issue_valid_i && is_x31(instr_i, `MSR_XO_COND_READ);
    wire dec_crwr = issue_valid_i && is_x31(instr_i, `MSR_XO_COND_WRITE);
    wire dec_xcr = issue_valid_i && is_x31(instr_i, `MSR_XO_FPX_TO_COND);
    // the I/O ordering barrier decodes to nothing: accesses already leave in order
    // and so it neither stalls nor produces any result
    // time base read differs only in bit 25 of the word (xo bit 5)
    wire dec_sprrd = issue_valid_i && (instr_i[31:26] == `MSR_OP_PRIMARY_31) &&
        (xo_nb25 == `MSR_XO_SPR_READ);

    // ==========================================
    // barriers
    // touch loads only block until translated, their bus phase is not awaited
    wire sync_busy = prior_excp_pending_i || prior_mem_pending_i ||
        prior_touch_xlate_pending_i;
    wire isync_busy = prior_excp_pending_i || prior_mem_pending_i;
    assign stall_o = (dec_sync && sync_busy) || (dec_isync && isync_busy);
    // barriers act inside the core only; this unit never requests the bus
    assign bus_req_o = 1'b0;

    // ==========================================
    // reservation
    reg rsv_valid_next;
    reg [31:0] rsv_addr_reg;
    wire snoop_hit;
    msr_gran_cmp u_snoop_cmp (
        .addr_a_i(snoop_addr_i),
        .addr_b_i(rsv_addr_reg),
        .hit_o(snoop_hit)
    );
    always @* begin
        rsv_valid_next = rsv_valid_o;
        if (snoop_write_valid_i && snoop_hit) begin
            rsv_valid_next = 1'b0;
        end
        if (dec_scond) begin
            rsv_valid_next = 1'b0;
        end
        // a new reservation wins over a snoop against the old one
        if (dec_lrsv) begin
            rsv_valid_next = 1'b1;
        end
    end

    // ==========================================
    // field-masked write, one lane per four-bit field
    // lane g follows mask bit 12+g; lanes not selected keep their old value
    wire [31:0] mask_wr_val;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_field
            assign mask_wr_val[4*g +: 4] = instr_i[12 + g] ? gpr_src_i[4*g +: 4] :
                condition_register_o[4*g +: 4];
        end
    endgenerate

    // ==========================================
    // condition register and results
    // later writers win in program order: masked write, exception copy, cond store
    reg [31:0] cond_next;
    always @* begin
        cond_next = condition_register_o;
        if (dec_crwr) begin
            cond_next = mask_wr_val;
        end
        if (dec_xcr) begin
            cond_next[(7 - instr_i[25:23])*4 +: 4] = fixed_point_exception_reg_i[31:28];
        end
        if (dec_scond) begin
            // success depends on the flag alone, never on address match
            cond_next[31:28] = {2'b00, rsv_valid_o, fixed_point_exception_reg_i[31]};
        end
    end

    always @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            rsv_valid_o <= `MSR_RSV_RESET;
            rsv_addr_reg <= 32'h00000000;
            condition_register_o <= `MSR_COND_RESET;
            flush_o <= 1'b0;
            refetch_addr_o <= 32'h00000000;
            store_perform_o <= 1'b0;
            gpr_wr_en_o <= 1'b0;
            gpr_wr_data_o <= 32'h00000000;
            fpx_clear_o <= 1'b0;
            spr_read_o <= 1'b0;
            dsi_excp_o <= 1'b0;
        end else begin
            rsv_valid_o <= rsv_valid_next;
            if (dec_lrsv) begin
                rsv_addr_reg <= effective_address_i;
            end
            condition_register_o <= cond_next;
            flush_o <= dec_isync && !isync_busy;
            refetch_addr_o <= instr_addr_i + 32'h00000004;
            store_perform_o <= dec_scond && rsv_valid_o;
            gpr_wr_en_o <= dec_crrd;
            gpr_wr_data_o <= condition_register_o;
            fpx_clear_o <= dec_xcr;
            spr_read_o <= dec_sprrd;
            // write-through attribute never faults these accesses
            dsi_excp_o <= 1'b0 && write_through_i;
        end
    end
endmodule // msr_sync_unit

//--- sim/msr_chk_monitor.sv
/* checker for the sync and reservation unit ports.
 assumes instr_i is held while stall_o is high. */
`timescale 1ns/1ps
`include "msr_map.vh"
module msr_chk (
    input wire clk_i,
    input wire rst_b_i,
    input wire issue_valid_i,
    input wire [31:0] instr_i,
    input wire prior_excp_pending_i,
    input wire prior_mem_pending_i,
    input wire prior_touch_xlate_pending_i,
    input wire stall_o,
    input wire flush_o,
    input wire store_perform_o,
    input wire spr_read_o,
    input wire dsi_excp_o,
    input wire bus_req_o,
    input wire rsv_valid_o
);
// ==========================================
// decode
wire tk = issue_valid_i && !stall_o;
wire [9:0] xo = instr_i[10:1];
wire p31 = instr_i[31:26] == `MSR_OP_PRIMARY_31;
wire snc = issue_valid_i && p31 && xo == `MSR_XO_SYNC;
wire stc = tk && p31 && xo == `MSR_XO_STORE_COND;
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_b_i);
a_no_bus: assert property (bus_req_o == 1'b0) else $error("bus request seen");
a_no_fault: assert property (!dsi_excp_o) else $error("storage fault seen");
a_sync_excp: assert property (snc && prior_excp_pending_i |-> stall_o) else $error("sync ran early");
a_sync_mem: assert property (snc && prior_mem_pending_i |-> stall_o) else $error("sync passed mem");
a_sync_touch: assert property (snc && prior_touch_xlate_pending_i |-> stall_o) else $error("sync passed touch");
a_cond_pass: assert property (stc && rsv_valid_o |=> store_perform_o) else $error("store lost");
a_cond_fail: assert property (stc && !rsv_valid_o |=> !store_perform_o) else $error("bad store");
a_cond_clear: assert property (stc |=> !rsv_valid_o) else $error("reservation kept");
a_load_rsv: assert property (tk && p31 && xo == `MSR_XO_LOAD_RSV |=> rsv_valid_o) else $error("no rsv");
a_isync_flush: assert property (tk && instr_i[31:26] == `MSR_OP_PRIMARY_19 && xo == `MSR_XO_ISYNC
    |=> flush_o ##1 !flush_o) else $error("flush pulse wrong");
a_spr_alias: assert property (tk && p31 && (xo & ~10'h020) == `MSR_XO_SPR_READ |=> spr_read_o)
    else $error("spr read missed");
endmodule // msr_chk
bind msr_sync_unit msr_chk msr_chk_i (.*);

//--- sim/msr_bus_model.sv
/* far-side bus model: another master whose stores are snooped.
 assumes the bench asks for one write at a time. */
`timescale 1ns/1ps
module msr_bus_model (
    input wire clk_i,
    input wire fire_i,
    input wire [31:0] addr_i,
    output reg snoop_write_valid_o,
    output reg [31:0] snoop_addr_o
);
// ==========================================
// snoop source
initial begin
    snoop_write_valid_o = 1'b0;
    snoop_addr_o = 32'h0;
end
// idle address toggles so a stale value is never mistaken for a write
always @(posedge clk_i) begin
    snoop_write_valid_o <= fire_i;
    snoop_addr_o <= fire_i ? addr_i : ~snoop_addr_o;
end
endmodule // msr_bus_model

//--- sim/tb_top.sv
/* self-checking bench of the sync and reservation unit.
 assumes the unit and its checker are compiled alongside. */
`timescale 1ns/1ps
`include "msr_map.vh"
module tb_top;
reg clk_i = 0, rst_b_i = 0, iv = 0, exc = 0, mem = 0, tch = 0, fire = 0;
reg [31:0] ins = 0, ia = 0, eff = 0, gpr = 0, fpx = 0, fa = 0;
integer n_errors = 0, checked = 0;
wire stall_o, flush_o, sp_o, gw_o, xc_o, sr_o, dsi_o, bus_o, rv_o, sv;
wire [31:0] ra_o, gd_o, cnd_o, sa;
always #2 clk_i = ~clk_i;
msr_sync_unit msr_sync_unit_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .issue_valid_i(iv), .instr_i(ins),
    .instr_addr_i(ia), .effective_address_i(eff), .gpr_src_i(gpr), .fixed_point_exception_reg_i(fpx),
    .write_through_i(1'b1), .prior_excp_pending_i(exc), .prior_mem_pending_i(mem),
    .prior_touch_xlate_pending_i(tch), .snoop_write_valid_i(sv), .snoop_addr_i(sa), .stall_o(stall_o),
    .flush_o(flush_o), .refetch_addr_o(ra_o), .store_perform_o(sp_o), .gpr_wr_en_o(gw_o),
    .gpr_wr_data_o(gd_o), .fpx_clear_o(xc_o), .spr_read_o(sr_o), .dsi_excp_o(dsi_o), .bus_req_o(bus_o),
    .condition_register_o(cnd_o), .rsv_valid_o(rv_o));
msr_bus_model msr_bus_model_i (.clk_i(clk_i), .fire_i(fire), .addr_i(fa), .snoop_write_valid_o(sv),
    .snoop_addr_o(sa));
// ==========================================
// helpers
task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
        checked = checked + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("unexpected %0s exp %h got %h", nm, e, g);
        end
    end
endtask
function [31:0] op(input [5:0] p, input [9:0] x);
    op = {p, 15'h0, x, 1'b0};
endfunction
// effective addresses handed in are always word aligned
task iss(input [31:0] i, input [31:0] a);
    begin
        @(posedge clk_i); #1 iv = 1; ins = i; eff = a;
        @(posedge clk_i); #1 iv = 0;
    end
endtask
task snp(input [31:0] a);
    begin
        @(posedge clk_i); #1 fire = 1; fa = a;
        @(posedge clk_i); #1 fire = 0;
        @(posedge clk_i); #1;
    end
endtask
task final_report;
    begin
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    end
endtask
// ==========================================
// scenarios
task t_rsv;
    begin
        iss(op(`MSR_OP_PRIMARY_31, `MSR_XO_LOAD_RSV), 32'h1000); chk("rsv", 1, rv_o);
        iss(op(`MSR_OP_PRIMARY_31, `MSR_XO_STORE_COND) | 1, 32'h2000); chk("store", 1, sp_o);
        chk("cr0", 1, cnd_o[29]); chk("rsv", 0, rv_o);
        iss(op(`MSR_OP_PRIMARY_31, `MSR_XO_STORE_COND) | 1, 32'h1000); chk("store", 0, sp_o);
        chk("cr0", 0, cnd_o[29]);
        iss(op(`MSR_OP_PRIMARY_31, `MSR_XO_LOAD_RSV), 32'h1000); snp(32'h101C); chk("rsv", 0, rv_o);
        iss(op(`MSR_OP_PRIMARY_31, `MSR_XO_LOAD_RSV), 32'h1004); snp(32'h1020); chk("rsv", 1, rv_o);
        iss(op(`MSR_OP_PRIMARY_31, `MSR_XO_LOAD_RSV), 32'h3000); snp(32'h1000); chk("rsv", 1, rv_o);
        $display("reservation test done");
    end
endtask
task t_sync;
    begin
        @(posedge clk_i); #1 mem = 1; iv = 1; ins = op(`MSR_OP_PRIMARY_31, `MSR_XO_IO_ORDER);
        @(posedge clk_i); #1 chk("stall", 0, stall_o);
        ins = op(`MSR_OP_PRIMARY_31, `MSR_XO_SYNC);
        repeat (3) @(posedge clk_i);
        #1 chk("stall", 1, stall_o);
        exc = 1; mem = 0;
        @(posedge clk_i); #1 chk("stall", 1, stall_o);
        exc = 0; tch = 1;
        @(posedge clk_i); #1 chk("stall", 1, stall_o);
        tch = 0;
        @(posedge clk_i); #1 chk("stall", 0, stall_o);
        @(posedge clk_i); #1 iv = 0; ia = 32'h100;
        iss(op(`MSR_OP_PRIMARY_19, `MSR_XO_ISYNC), 0); chk("flush", 1, flush_o);
        chk("refetch", 32'h104, ra_o);
        $display("sync test done");
    end
endtask
task t_cr;
    begin
        gpr = 32'hFFFFFFFF; fpx = 32'h80000000;
        iss(op(`MSR_OP_PRIMARY_31, `MSR_XO_COND_WRITE) | 32'h81000, 0); chk("cr", 32'hF000000F, cnd_o);
        iss(op(`MSR_OP_PRIMARY_31, `MSR_XO_COND_READ), 0); chk("crread", 32'hF000000F, gd_o);
        chk("gwen", 1, gw_o);
        iss(op(`MSR_OP_PRIMARY_31, `MSR_XO_FPX_TO_COND), 0); chk("xclr", 1, xc_o);
        chk("crcopy", 32'h8000000F, cnd_o);
        iss(op(`MSR_OP_PRIMARY_31, `MSR_XO_SPR_READ), 0); chk("spr", 1, sr_o);
        iss(op(`MSR_OP_PRIMARY_31, `MSR_XO_SPR_READ | 10'h020), 0); chk("tb", 1, sr_o);
        $display("register move test done");
    end
endtask
initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_b_i = 1;
    repeat (3) @(posedge clk_i);
    #1 chk("rsv", 0, rv_o);
    t_rsv;
    t_sync;
    t_cr;
    final_report;
end
endmodule // tb_top
